// ==== uq_pkg.sv ====
// uq_pkg: shared constants and types for the upconverter input port block.
// assumes one system clock; every count below is in cycles of that clock.
`default_nettype none

package uq_pkg;

    // data widths
    localparam int WORD_W     = 14;
    localparam int PAIR_W     = 2 * WORD_W;
    localparam int FTW_W      = 32;
    localparam int PROD_W     = 2 * WORD_W;
    localparam int SCALE_W    = 8;
    localparam int SCALE_SHR  = 7;
    localparam int FIFO_DEPTH = 8;

    // word clock: half period in system clock cycles (plain default)
    localparam int WCLK_HALF   = 2;
    localparam int WCLK_PERIOD = 2 * WCLK_HALF;
    localparam int DIV_W       = $clog2(WCLK_PERIOD);
    localparam logic [DIV_W-1:0] WCLK_LAST = DIV_W'(WCLK_PERIOD - 1);
    localparam logic [DIV_W-1:0] WCLK_HIGH = DIV_W'(WCLK_HALF);

    // synthesizer lookup: phase bits used and quarter-wave offset for cosine
    localparam int          LUT_BITS = 6;
    localparam logic [5:0]  COS_OFS  = 6'h10;

    // operating modes as written by the control word
    typedef enum logic [1:0] {
        MODE_QUAD = 2'h0,
        MODE_TONE = 2'h1,
        MODE_IDAC = 2'h2
    } uq_mode_e;

    // word phase tracker, one-hot
    typedef enum logic [2:0] {
        PH_IDLE = 3'h1,
        PH_I    = 3'h2,
        PH_Q    = 3'h4
    } uq_phase_e;

    // reset values, and the unity output scale factor
    localparam uq_mode_e          MODE_RST = MODE_QUAD;
    localparam logic [FTW_W-1:0]  FTW_RST  = 32'h0;
    localparam logic [SCALE_W-1:0] SCALE_UNITY = 8'h80;

endpackage : uq_pkg

`default_nettype wire

// ==== uq_fifo.sv ====
// uq_fifo: synchronous first-word-fall-through fifo with valid/ready both sides.
// assumes one clock and synchronous active-high reset; flush empties it at once.
`default_nettype none

module uq_fifo #(
    parameter int W = 28,
    parameter int D = 8
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         flush,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0]         wp;
        logic [AW:0]         rp;
    } uq_fifo_s;

    uq_fifo_s s_r;
    uq_fifo_s s_nxt;
    logic     full;
    logic     empty;

    // extra pointer bit tells full from empty when the indices meet
    assign full      = (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]) && (s_r.wp[AW] != s_r.rp[AW]);
    assign empty     = (s_r.wp == s_r.rp);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = s_r.mem[s_r.rp[AW-1:0]];

    // write and read advance independently
    always_comb begin
        s_nxt = s_r;
        if (in_valid && !full) begin
            s_nxt.mem[s_r.wp[AW-1:0]] = in_data;
            s_nxt.wp = s_r.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        if (flush) begin
            s_nxt.wp = '0;
            s_nxt.rp = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule : uq_fifo

`default_nettype wire

// ==== uq_nco.sv ====
// uq_nco: phase accumulator with quarter-wave sine table, cosine and sine out.
// assumes a load pulse carries a new tuning word; outputs lag the phase by one cycle.
`default_nettype none

module uq_nco (
    input  wire logic                       clock,
    input  wire logic                       rst,
    input  wire logic                       enable,
    input  wire logic                       load,
    input  wire logic [uq_pkg::FTW_W-1:0]   ftw_in,
    output logic [uq_pkg::WORD_W-1:0]       cos_out,
    output logic [uq_pkg::WORD_W-1:0]       sin_out
);

    typedef struct packed {
        logic [uq_pkg::FTW_W-1:0]  frequency_tuning_word;
        logic [uq_pkg::FTW_W-1:0]  acc;
        logic [uq_pkg::WORD_W-1:0] cosv;
        logic [uq_pkg::WORD_W-1:0] sinv;
    } uq_nco_s;

    uq_nco_s s_r;
    uq_nco_s s_nxt;

    // quarter-wave magnitude table, half-step offset avoids a zero entry
    function automatic logic [13:0] quarter(input logic [3:0] i);
        unique case (i)
            4'h0: quarter = 14'h0192;
            4'h1: quarter = 14'h04B2;
            4'h2: quarter = 14'h07C6;
            4'h3: quarter = 14'h0AC8;
            4'h4: quarter = 14'h0DAE;
            4'h5: quarter = 14'h1073;
            4'h6: quarter = 14'h130F;
            4'h7: quarter = 14'h157D;
            4'h8: quarter = 14'h17B5;
            4'h9: quarter = 14'h19B3;
            4'hA: quarter = 14'h1B72;
            4'hB: quarter = 14'h1CED;
            4'hC: quarter = 14'h1E20;
            4'hD: quarter = 14'h1F0A;
            4'hE: quarter = 14'h1FA6;
            4'hF: quarter = 14'h1FF5;
        endcase
    endfunction : quarter

    // full wave from quadrant folding
    function automatic logic [13:0] sine(input logic [5:0] p);
        logic [13:0] m;
        m = p[4] ? quarter(~p[3:0]) : quarter(p[3:0]);
        sine = p[5] ? 14'(-m) : m;
    endfunction : sine

    always_comb begin
        s_nxt = s_r;
        if (load) begin
            s_nxt.frequency_tuning_word = ftw_in;
            s_nxt.acc = '0;           // synthesis restarts from phase zero
        end else if (enable) begin
            s_nxt.acc = s_r.acc + s_r.frequency_tuning_word;
        end else begin
            s_nxt.acc = '0;
        end
        s_nxt.sinv = sine(s_r.acc[uq_pkg::FTW_W-1 -: uq_pkg::LUT_BITS]);
        s_nxt.cosv = sine(s_r.acc[uq_pkg::FTW_W-1 -: uq_pkg::LUT_BITS] + uq_pkg::COS_OFS);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_r      <= '0;
            s_r.frequency_tuning_word  <= uq_pkg::FTW_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cos_out = s_r.cosv;
    assign sin_out = s_r.sinv;

endmodule : uq_nco

`default_nettype wire

// ==== uq_port.sv ====
// uq_port: parallel input port, word assembler and mode control of the upconverter.
// assumes all inputs are synchronous to clock (the internal system clock) and that
// mode, qualify bit, scale and profile tuning words come from a control register
// outside this block.
//
// Function
// - three modes, quadrature modulation, single tone, interpolating dac; quadrature after reset.
// - mode comes from control word; output scaling acts in every mode.
// - in quadrature mode the shared pin is driven out as the word clock.
// - word clock at twice path rate; alternating i and q words form one sample.
// - interleaved words are split into i and q paths, pair rate half word rate.
// - words in quadrature and dac modes are 14-bit two's complement.
// - i times cosine plus q times sine forms the modulated stream.
// - single tone disables data paths; shared pin becomes update strobe input.
// - single tone outputs synthesizer cosine at the active profile frequency.
// - update strobe rising edge loads selected profile tuning word into accumulator.
// - profile select change applies its tuning word without an update strobe.
// - dac mode disables synthesizer, modulator and q path; i passes at baseband.
// - in dac mode every word clock rising edge captures one word into i.
// - word clock runs continuously, optionally gated by multiplier lock indication; here a full fifo also holds it low.
// - quadrature mode with transmit gate low ignores input and flushes zeros.
// - after gate rises, capture i, then q, alternating until gate falls.
// - system clock is reference direct or multiplied; all timing derives from it.
`default_nettype none

module uq_port (
    input  wire logic                         clock,
    input  wire logic                         rst,
    input  wire logic [1:0]                   mode_sel,
    input  wire logic                         lock_qualify,
    input  wire logic                         pll_locked,
    input  wire logic                         transmit_gate,
    input  wire logic [uq_pkg::WORD_W-1:0]    data_word,
    input  wire logic                         word_pin_in,
    output logic                              word_pin_out,
    output logic                              word_pin_oe,
    input  wire logic                         profile_select_bit0,
    input  wire logic                         profile_select_bit1,
    input  wire logic [uq_pkg::FTW_W-1:0]     ftw_profile0,
    input  wire logic [uq_pkg::FTW_W-1:0]     ftw_profile1,
    input  wire logic [uq_pkg::FTW_W-1:0]     ftw_profile2,
    input  wire logic [uq_pkg::FTW_W-1:0]     ftw_profile3,
    input  wire logic [uq_pkg::SCALE_W-1:0]   out_scale,
    input  wire logic                         sample_ready,
    output logic [uq_pkg::WORD_W-1:0]         mod_sample,
    output logic                              mod_valid,
    output logic [1:0]                        mode_active
);

    typedef struct packed {
        uq_pkg::uq_mode_e           mode;
        logic [uq_pkg::DIV_W-1:0]   div;
        logic                       wclk;
        logic                       oe;
        uq_pkg::uq_phase_e          phase;
        logic                       tx_prev;
        logic                       flush_tog;
        logic [uq_pkg::WORD_W-1:0]  i_hold;
        logic [1:0]                 prof_prev;
        logic                       load_pend;
        logic                       upd_prev;
        logic                       ftw_load;
        logic [uq_pkg::FTW_W-1:0]   ftw_sel;
        logic [uq_pkg::WORD_W-1:0]  out;
        logic                       out_v;
    } uq_port_s;

    uq_port_s s_r;
    uq_port_s s_nxt;

    // fifo and synthesizer hookup
    logic                          push;
    logic [uq_pkg::PAIR_W-1:0]     push_data;
    logic                          fifo_in_ready;
    logic                          fifo_out_valid;
    logic                          pop;
    logic [uq_pkg::PAIR_W-1:0]     fifo_out_data;
    logic [uq_pkg::WORD_W-1:0]     cos_w;
    logic [uq_pkg::WORD_W-1:0]     sin_w;

    // per-cycle working values of the combinational process
    logic                          run;
    logic                          strobe;
    logic                          upd_rise;
    logic [1:0]                    prof;
    uq_pkg::uq_phase_e             ph;
    logic [uq_pkg::PROD_W:0]       mix;

    // signed 14 x 14 product, full width
    function automatic logic [uq_pkg::PROD_W-1:0] prod(
        input logic [uq_pkg::WORD_W-1:0] a,
        input logic [uq_pkg::WORD_W-1:0] b
    );
        prod = uq_pkg::PROD_W'($signed(a) * $signed(b));
    endfunction : prod

    // output scale: unsigned 1.7 factor with saturation instead of wrap
    function automatic logic [uq_pkg::WORD_W-1:0] scale_word(
        input logic [uq_pkg::WORD_W-1:0]  v,
        input logic [uq_pkg::SCALE_W-1:0] k
    );
        logic signed [22:0] p;
        p = 23'($signed(v) * $signed({1'b0, k}));
        if (p[22:20] == 3'h0 || p[22:20] == 3'h7) begin
            scale_word = p[20:7];
        end else begin
            scale_word = p[22] ? 14'h2000 : 14'h1FFF;
        end
    endfunction : scale_word

    // illegal mode code falls back to quadrature
    function automatic uq_pkg::uq_mode_e mode_decode(input logic [1:0] m);
        unique case (m)
            2'h1:    mode_decode = uq_pkg::MODE_TONE;
            2'h2:    mode_decode = uq_pkg::MODE_IDAC;
            default: mode_decode = uq_pkg::MODE_QUAD;
        endcase
    endfunction : mode_decode

    // pairs of {i, q}; back-pressure stalls the word clock, not the data
    uq_fifo #(
        .W (uq_pkg::PAIR_W),
        .D (uq_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .flush     (s_r.mode == uq_pkg::MODE_TONE),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data),
        .out_valid (fifo_out_valid),
        .out_ready (pop),
        .out_data  (fifo_out_data)
    );

    // synthesizer is held idle in dac mode
    uq_nco u_nco (
        .clock   (clock),
        .rst     (rst),
        .enable  (s_r.mode != uq_pkg::MODE_IDAC),
        .load    (s_r.ftw_load),
        .ftw_in  (s_r.ftw_sel),
        .cos_out (cos_w),
        .sin_out (sin_w)
    );

    // whole next state in one pass: word clock, capture, tuning, output
    always_comb begin
        s_nxt      = s_r;
        push       = 1'b0;
        push_data  = '0;
        pop        = 1'b0;
        strobe     = 1'b0;
        mix        = '0;
        ph         = s_r.phase;
        s_nxt.ftw_load = 1'b0;
        s_nxt.mode = mode_decode(mode_sel);

        // word clock: pin driven unless single tone
        s_nxt.oe = (s_r.mode != uq_pkg::MODE_TONE);
        run = (s_r.mode != uq_pkg::MODE_TONE)
              && (!lock_qualify || pll_locked);

        // divider off the system clock; a full fifo holds the clock low
        // so the source never presents a word we cannot keep
        if (!run) begin
            s_nxt.div  = uq_pkg::WCLK_LAST;
            s_nxt.wclk = 1'b0;
        end else if (s_r.div == uq_pkg::WCLK_LAST) begin
            if (fifo_in_ready) begin
                strobe     = 1'b1;
                s_nxt.div  = '0;
                s_nxt.wclk = 1'b1;
            end else begin
                s_nxt.wclk = 1'b0;
            end
        end else begin
            s_nxt.div  = s_r.div + 1'b1;
            s_nxt.wclk = (s_nxt.div < uq_pkg::WCLK_HIGH);
        end

        // capture coincides with the rising edge the pin shows next cycle
        if (strobe) begin
            unique case (s_r.mode)
                uq_pkg::MODE_QUAD: begin
                    s_nxt.tx_prev = transmit_gate;
                    if (!transmit_gate) begin
                        // input ignored, zero pairs at pair rate
                        s_nxt.phase     = uq_pkg::PH_IDLE;
                        s_nxt.flush_tog = ~s_r.flush_tog;
                        push            = s_r.flush_tog;
                        push_data       = '0;
                    end else begin
                        if (!s_r.tx_prev) begin
                            ph = uq_pkg::PH_IDLE;
                        end
                        unique case (ph)
                            uq_pkg::PH_IDLE, uq_pkg::PH_I: begin
                                s_nxt.i_hold = data_word;
                                s_nxt.phase  = uq_pkg::PH_Q;
                            end
                            uq_pkg::PH_Q: begin
                                push        = 1'b1;
                                push_data   = {s_r.i_hold, data_word};
                                s_nxt.phase = uq_pkg::PH_I;
                            end
                        endcase
                    end
                end
                uq_pkg::MODE_IDAC: begin
                    // every edge is an i word; q half of the pair stays zero
                    s_nxt.tx_prev = 1'b0;
                    s_nxt.phase   = uq_pkg::PH_IDLE;
                    push          = 1'b1;
                    push_data     = {data_word, uq_pkg::WORD_W'(0)};
                end
                uq_pkg::MODE_TONE: begin
                    s_nxt.tx_prev = 1'b0;
                end
            endcase
        end
        if (s_r.mode == uq_pkg::MODE_TONE) begin
            s_nxt.tx_prev = 1'b0;
            s_nxt.phase   = uq_pkg::PH_IDLE;
        end

        // tuning word selection: profile change or update strobe edge
        prof            = {profile_select_bit1, profile_select_bit0};
        s_nxt.prof_prev = prof;
        s_nxt.upd_prev  = (s_r.mode == uq_pkg::MODE_TONE) && word_pin_in;
        upd_rise        = (s_r.mode == uq_pkg::MODE_TONE) && word_pin_in && !s_r.upd_prev;
        if (upd_rise || prof != s_r.prof_prev || s_r.load_pend) begin
            s_nxt.ftw_load  = 1'b1;
            s_nxt.load_pend = 1'b0;
            unique case (prof)
                2'h0: s_nxt.ftw_sel = ftw_profile0;
                2'h1: s_nxt.ftw_sel = ftw_profile1;
                2'h2: s_nxt.ftw_sel = ftw_profile2;
                2'h3: s_nxt.ftw_sel = ftw_profile3;
            endcase
        end

        // output stage holds its word until downstream takes it
        if (s_r.out_v && sample_ready) begin
            s_nxt.out_v = 1'b0;
        end
        if (!s_r.out_v || sample_ready) begin
            unique case (s_r.mode)
                uq_pkg::MODE_QUAD: begin
                    if (fifo_out_valid) begin
                        pop = 1'b1;
                        // sum halved so |i cos + q sin| cannot wrap
                        mix = {prod(fifo_out_data[27:14], cos_w)[27],
                               prod(fifo_out_data[27:14], cos_w)}
                            + {prod(fifo_out_data[13:0], sin_w)[27],
                               prod(fifo_out_data[13:0], sin_w)};
                        s_nxt.out   = scale_word(mix[27:14], out_scale);
                        s_nxt.out_v = 1'b1;
                    end
                end
                uq_pkg::MODE_TONE: begin
                    s_nxt.out   = scale_word(cos_w, out_scale);
                    s_nxt.out_v = 1'b1;
                end
                uq_pkg::MODE_IDAC: begin
                    if (fifo_out_valid) begin
                        pop = 1'b1;
                        // baseband pass, q half discarded
                        s_nxt.out   = scale_word(fifo_out_data[27:14], out_scale);
                        s_nxt.out_v = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_r           <= '0;
            s_r.mode      <= uq_pkg::MODE_RST;
            s_r.div       <= uq_pkg::WCLK_LAST;
            s_r.phase     <= uq_pkg::PH_IDLE;
            s_r.ftw_sel   <= uq_pkg::FTW_RST;
            s_r.load_pend <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // every output straight from the state register
    assign word_pin_out = s_r.wclk;
    assign word_pin_oe  = s_r.oe;
    assign mod_sample   = s_r.out;
    assign mod_valid    = s_r.out_v;
    assign mode_active  = s_r.mode;

endmodule : uq_port

`default_nettype wire

// ==== uq_port_sva.sv ====
// uq_port_sva: port-level checks of uq_port, bound into every instance.
// assumes sample_ready comes from the far side and may stall at will.
`default_nettype none

module uq_port_sva (
    input wire logic                      clock,
    input wire logic                      rst,
    input wire logic [1:0]                mode_sel,
    input wire logic                      lock_qualify,
    input wire logic                      pll_locked,
    input wire logic                      word_pin_out,
    input wire logic                      word_pin_oe,
    input wire logic                      sample_ready,
    input wire logic [uq_pkg::WORD_W-1:0] mod_sample,
    input wire logic                      mod_valid,
    input wire logic [1:0]                mode_active
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // pin free to run: not tone mode, not held by lock
    sequence calm_s;
        mode_sel != 2'h1 && (!lock_qualify || pll_locked);
    endsequence
    sequence rise_s;
        $rose(word_pin_out);
    endsequence

    // reset must be checked while it is asserted, so no disable here
    rst_clear_a: assert property (disable iff (1'b0)
        rst |=> !word_pin_oe && !word_pin_out && !mod_valid && mode_active == 2'h0)
        else $error("outputs not cleared by reset");
    tone_release_a: assert property ((mode_sel == 2'h1)[*3] |-> !word_pin_oe)
        else $error("pin still driven in tone mode");
    drive_pin_a: assert property ((mode_sel != 2'h1)[*3] |-> word_pin_oe)
        else $error("pin not driven outside tone mode");
    pin_high_a: assert property (
        rise_s ##0 calm_s[*3] |-> $past(word_pin_out) && !word_pin_out)
        else $error("word clock high phase not two cycles");
    pin_low_a: assert property ($fell(word_pin_out) |=> !word_pin_out)
        else $error("word clock low phase too short");
    lock_gate_a: assert property ((lock_qualify && !pll_locked)[*4] |-> !word_pin_out)
        else $error("word clock runs without lock");
    stall_hold_a: assert property (mod_valid && !sample_ready |=> mod_valid && $stable(mod_sample))
        else $error("output changed while stalled");
    tone_valid_a: assert property ((mode_sel == 2'h1)[*4] |-> mod_valid)
        else $error("tone output not continuous");
    mode_track_a: assert property (!$past(rst) && !$past(rst, 2) |->
        mode_active == ($past(mode_sel) == 2'h3 ? 2'h0 : $past(mode_sel)))
        else $error("mode in effect does not follow selection");
endmodule : uq_port_sva

bind uq_port uq_port_sva uq_port_sva_inst (.clock, .rst, .mode_sel, .lock_qualify,
    .pll_locked, .word_pin_out, .word_pin_oe, .sample_ready, .mod_sample, .mod_valid,
    .mode_active);

`default_nettype wire

// ==== uq_src.sv ====
// uq_src: behavioural data source at the parallel port, paced by the word clock.
// assumes pin is the resolved wire; each word is held until the next rise is seen.
`default_nettype none

module uq_src (
    input  wire logic                      clock,
    input  wire logic                      pin,
    input  wire logic                      start,
    input  wire logic [7:0]                pairs,
    input  wire logic [uq_pkg::WORD_W-1:0] word_i,
    input  wire logic [uq_pkg::WORD_W-1:0] word_q,
    output var logic [uq_pkg::WORD_W-1:0]  data_word,
    output var logic                       transmit_gate,
    output var logic                       busy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic pin_q = 1'b0, go_q = 1'b0;
    int   idx   = 0;

    initial {data_word, transmit_gate, busy} = '0;

    // start is taken at the edge so the bench's release cannot race it; idle bus toggles
    always @(posedge clock) begin
        go_q = start;
        #1;
        if (go_q && !busy) begin
            busy          = 1'b1;
            idx           = 0;
            transmit_gate = 1'b1;
            data_word     = word_i;
        end else if (busy && pin && !pin_q) begin
            idx = idx + 1;
            if (idx == 2 * int'(pairs)) begin
                busy          = 1'b0;
                transmit_gate = 1'b0;
                data_word     = ~data_word;
            end else begin
                data_word = idx[0] ? word_q : word_i;
            end
        end else if (!busy) begin
            data_word = ~data_word;
        end
        pin_q = pin;
    end
endmodule : uq_src

`default_nettype wire

// ==== testbench.sv ====
// testbench: drives uq_port through the source model and judges its ports.
// assumes package, design, checker and source files are compiled first.
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin bad_count++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end

module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    typedef logic [uq_pkg::WORD_W-1:0] uq_word_t;
    logic      clock = 1'b0, rst = 1'b1, lock_qualify = 1'b0, pll_locked = 1'b1;
    logic      strobe = 1'b0, sel_bit0 = 1'b0, sample_ready = 1'b1, start = 1'b0;
    logic [1:0] mode_sel = 2'h0;
    logic [7:0] pairs = 8'h3C;
    logic [31:0] ftw0 = 32'h0, ftw1 = 32'h0;
    logic [7:0] out_scale = uq_pkg::SCALE_UNITY;
    uq_word_t  word_i = 14'h0, word_q = 14'h0, data_word, mod_sample, v;
    logic      transmit_gate, word_pin_out, word_pin_oe, mod_valid, busy, pin;
    logic [1:0] mode_active;
    int        bad_count = 0, check_count = 0, h, pos, neg;

    always #12.5 clock = ~clock;
    // tone mode: bench drives the pin as update strobe
    assign pin = word_pin_oe ? word_pin_out : strobe;

    uq_port uq_port_inst (.clock, .rst, .mode_sel, .lock_qualify, .pll_locked, .transmit_gate,
        .data_word, .word_pin_in(pin), .word_pin_out, .word_pin_oe,
        .profile_select_bit0(sel_bit0), .profile_select_bit1(1'b0), .ftw_profile0(ftw0),
        .ftw_profile1(ftw1), .ftw_profile2(32'h0), .ftw_profile3(32'h0), .out_scale,
        .sample_ready, .mod_sample, .mod_valid, .mode_active);
    uq_src uq_src_inst (.clock, .pin, .start, .pairs, .word_i, .word_q, .data_word,
        .transmit_gate, .busy);

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step
    // next sample handed over, bounded wait
    task automatic take(output uq_word_t s);
        int k = 0;
        step(1);
        while (!(mod_valid === 1'b1 && sample_ready === 1'b1) && k < 50) begin
            step(1);
            k++;
        end
        s = mod_sample;
    endtask : take
    task automatic highs(output int n);
        n = 0;
        repeat (8) begin
            step(1);
            n += int'(word_pin_out === 1'b1);
        end
    endtask : highs
    task automatic go(input uq_word_t wi, input uq_word_t wq, input logic [7:0] np);
        int k = 0;
        while (busy === 1'b1 && k < 2000) begin
            step(1);
            k++;
        end
        word_i = wi;
        word_q = wq;
        pairs = np;
        start = 1'b1;
        step(1);
        start = 1'b0;
    endtask : go
    task automatic dac_val(input uq_word_t w, input logic [7:0] k, input uq_word_t ex);
        word_i = w;
        word_q = w;
        out_scale = k;
        step(40);
        repeat (4) begin
            take(v);
            `CHK("dac_sample", ex, v)
        end
    endtask : dac_val

    task automatic t_reset;
        step(10);
        rst = 1'b0;
        `CHK("mode_active", 2'h0, mode_active)
        step(3);
        `CHK("pin_oe", 1'b1, word_pin_oe)
        $display("test reset done");
    endtask : t_reset
    // dac mode; a long stall fills the fifo and stops the clock
    task automatic t_dac;
        mode_sel = 2'h2;
        go(14'h0ABC, 14'h0ABC, 8'h3C);
        dac_val(14'h0ABC, 8'h80, 14'h0ABC);
        dac_val(14'h3F00, 8'h40, 14'h3F80);
        dac_val(14'h1F00, 8'hFF, 14'h1FFF);
        sample_ready = 1'b0;
        step(50);
        highs(h);
        `CHK("full_pin", 0, h)
        sample_ready = 1'b1;
        take(v);
        `CHK("drain", 14'h1FFF, v)
        out_scale = uq_pkg::SCALE_UNITY;
        $display("test dac done");
    endtask : t_dac
    task automatic t_lock;
        mode_sel = 2'h0;
        lock_qualify = 1'b1;
        pll_locked = 1'b0;
        step(10);
        highs(h);
        `CHK("unlocked_pin", 0, h)
        pll_locked = 1'b1;
        step(10);
        highs(h);
        `CHK("locked_pin", 4, h)
        lock_qualify = 1'b0;
        $display("test lock done");
    endtask : t_lock
    // i-only stream at carrier phase 0 keeps the sign of i
    task automatic t_quad;
        go(14'h1000, 14'h0000, 8'h10);
        step(1);
        repeat (4) take(v);
        pos = 0;
        neg = 0;
        repeat (30) begin
            take(v);
            neg += int'(v[13]);
            pos += int'(!v[13] && v >= 14'h0100);
        end
        `CHK("quad_pos", 1'b1, pos > 0)
        `CHK("quad_neg", 0, neg)
        go(14'h0000, 14'h0000, 8'h01);
        step(60);
        take(v);
        `CHK("flush_zero", 14'h0000, v)
        $display("test quad done");
    endtask : t_quad
    task automatic t_tone;
        mode_sel = 2'h1;
        step(4);
        `CHK("tone_oe", 1'b0, word_pin_oe)
        strobe = 1'b1;
        step(2);
        strobe = 1'b0;
        step(10);
        v = mod_sample;
        step(10);
        `CHK("tone_steady", v, mod_sample)
        ftw0 = 32'h04000000;
        step(10);
        `CHK("no_strobe", v, mod_sample)
        strobe = 1'b1;
        step(2);
        strobe = 1'b0;
        h = 0;
        repeat (20) begin
            step(1);
            h += int'(mod_sample !== v);
        end
        `CHK("strobe_moves", 1'b1, h > 0)
        sel_bit0 = 1'b1;
        step(10);
        `CHK("profile_load", v, mod_sample)
        $display("test tone done");
    endtask : t_tone

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // tests take under 2000 cycles
    initial begin
        #125000;
        bad_count++;
        close_out();
    end
    initial begin
        t_reset();
        t_dac();
        t_lock();
        t_quad();
        t_tone();
        close_out();
    end
endmodule : testbench

`default_nettype wire
